// file: hdl/adcprp_consts.svh
`ifndef ADCPRP_CONSTS_SVH
`define ADCPRP_CONSTS_SVH
// Conversion time limit in nanoseconds
`define ADCPRP_CONV_TIME_NS 2700
// Acquisition gap between conversions in nanoseconds
`define ADCPRP_ACQ_GAP_NS 600
// Clock period in nanoseconds
`define ADCPRP_CLK_PERIOD_NS 40
// Longest time rounds down to whole cycles
`define ADCPRP_CONV_CYCLES (`ADCPRP_CONV_TIME_NS / `ADCPRP_CLK_PERIOD_NS)
// Result width and low byte width
`define ADCPRP_RES_W 12
`define ADCPRP_LOW_BYTE_W 8
// Field positions of the result
`define ADCPRP_HI_NIB_MSB 11
`define ADCPRP_HI_NIB_LSB 8
// Reset value of the output latch
`define ADCPRP_RESULT_RST 12'h000
`endif

// file: hdl/adcprp_pkg.sv
`default_nettype none
package adcprp_pkg;
  typedef logic [11:0] adcprp_result_t;
  typedef enum logic [1:0] {
    ADCPRP_IDLE = 2'b00,
    ADCPRP_CONV = 2'b01,
    ADCPRP_DONE = 2'b11
  } adcprp_state_t;
endpackage
`default_nettype wire

// file: hdl/adcprp_port.sv
// Contract
// - Result right aligned, LSB on lowest pin
// - Byte select steers result onto low pins
// - Top four bits on upper pins always
// - Select, read, byte-low start conversion, busy low
// - Starting read shows previous result
// - Latch updated before busy returns high
// - Low byte read returns bits seven-zero
// - High byte read starts nothing, pins seven-four zeroed
// - Pipelined read starts conversion, returns previous
// - Third read returns low byte, restarts
// - Top four bits on upper pins every read
// - Start needs all three inputs low
// - Starts ignored while converting
// - Conversion finishes within 2.7 microseconds; busy stays low CONV_CYCLES + 1 cycles, 2720 ns by default
`include "adcprp_consts.svh"
`default_nettype none
module adcprp_port #(
  parameter int CONV_CYCLES = `ADCPRP_CONV_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    chip_select_n,
  input  wire logic                    read_n,
  input  wire logic                    upper_byte_select,
  output logic                         busy_n,
  output logic [11:0]                  data_output_pins_o,
  output logic [11:0]                  data_output_pins_oe,
  input  wire adcprp_pkg::adcprp_result_t sample_data,
  input  wire logic                    sample_valid,
  output logic                         sample_ready
);
  import adcprp_pkg::*;

  // Pin synchronisers, two stages each
  // The host has no clock of ours, so every control pin is treated as
  // asynchronous; only the second stage is read by any logic.
  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  logic       cs_n_s;
  logic       rd_n_s;
  logic       ube_s;
  logic       access;
  logic       access_q, access_d;
  logic       start_cond;

  // Next values of the pin stages and of the access history
  always_comb begin
    sync1_d  = {chip_select_n, read_n, upper_byte_select};
    sync2_d  = sync1_q;
    access_d = access;
  end

  // Stages reset to idle pin levels, so no false access edge after reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q  <= 3'b110;
      sync2_q  <= 3'b110;
      access_q <= 1'b0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      access_q <= access_d;
    end
  end

  // Synchronised pin levels and the access decode
  assign cs_n_s = sync2_q[2];
  assign rd_n_s = sync2_q[1];
  assign ube_s  = sync2_q[0];
  assign access = !cs_n_s && !rd_n_s;
  // All three inputs low, on the first cycle of the access (access high, access_q low)
  assign start_cond = access && !access_q && !ube_s;

  // Sample path: converter core output passes through the buffer
  adcprp_result_t buf_data;
  logic           buf_valid, buf_ready;

  adcprp_skid #(
    .WIDTH(`ADCPRP_RES_W)
  ) u_skid (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .in_valid (sample_valid),
    .in_ready (sample_ready),
    .in_data  (sample_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data (buf_data)
  );

  // Conversion sequencer
  // A start is taken only in idle; the counter times the conversion and
  // the result latch is loaded on its last cycle. Busy is released one
  // cycle later, so the host never sees busy high with stale data.
  // A held-low access starts once only: a new start needs the access to
  // be released and taken again, which keeps a slow host from retriggering.
  adcprp_state_t  state_q, state_d;
  logic [15:0]    cnt_q, cnt_d;
  adcprp_result_t result_q, result_d;
  logic           busy_n_q, busy_n_d;

  function automatic logic [15:0] last_count(input int cycles);
    return (cycles < 1) ? 16'd0 : 16'(cycles - 1);
  endfunction

  // Last cycle of the conversion count
  logic conv_last;
  assign conv_last = (state_q == ADCPRP_CONV) && (cnt_q == last_count(CONV_CYCLES));

  // Buffer is drained only at end of conversion
  // An empty buffer then leaves the previous result in the latch.
  assign buf_ready = conv_last;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    busy_n_d = busy_n_q;
    case (state_q)
      ADCPRP_IDLE: begin
        if (start_cond) begin
          state_d  = ADCPRP_CONV;
          cnt_d    = 16'd0;
          busy_n_d = 1'b0;
        end
      end
      ADCPRP_CONV: begin
        // Further starts ignored here
        if (conv_last) begin
          if (buf_valid) begin
            result_d = buf_data;
          end
          state_d = ADCPRP_DONE;
        end else begin
          cnt_d = cnt_q + 16'd1;
        end
      end
      ADCPRP_DONE: begin
        // Latch already updated, busy released one cycle later
        busy_n_d = 1'b1;
        state_d  = ADCPRP_IDLE;
      end
      default: begin
        state_d  = ADCPRP_IDLE;
        busy_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= ADCPRP_IDLE;
      cnt_q    <= 16'd0;
      result_q <= `ADCPRP_RESULT_RST;
      busy_n_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
      busy_n_q <= busy_n_d;
    end
  end

  assign busy_n = busy_n_q;

  // Top four result bits, shown on the upper pins, and on the low lane for high-byte reads
  function automatic logic [3:0] top_nibble(input adcprp_result_t r);
    return r[`ADCPRP_HI_NIB_MSB:`ADCPRP_HI_NIB_LSB];
  endfunction

  // Pin word for one access: full word, or top nibble on the low lane
  function automatic logic [11:0] pin_word(input adcprp_result_t r, input logic upper);
    logic [11:0] w;
    w = r;
    if (upper) begin
      w[7:0] = {4'h0, top_nibble(r)};
    end
    // Top nibble always on upper pins
    w[11:8] = top_nibble(r);
    return w;
  endfunction

  // Output data mux, registered; latch holds old data during conversion
  // The pins follow the synchronised access with one cycle of lag, so a
  // host must allow three clock cycles from its strobe to valid data.
  logic [11:0] dout_q, dout_d;
  logic [11:0] oe_q, oe_d;

  // Next pin data and enables
  always_comb begin
    dout_d = pin_word(result_q, ube_s);
    oe_d   = access ? 12'hFFF : 12'h000;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_q <= 12'h000;
      oe_q   <= 12'h000;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  assign data_output_pins_o  = dout_q;
  assign data_output_pins_oe = oe_q;
endmodule
`default_nettype wire

// file: hdl/adcprp_skid.sv
`include "adcprp_consts.svh"
`default_nettype none
module adcprp_skid #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // Two-entry store, pointers and count
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             wr_q, wr_d, rd_q, rd_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next-state for pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'd1;
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// file: verification/adcprp_chk_asserts.sv
`default_nettype none
module adcprp_chk #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        chip_select_n,
  input wire logic        read_n,
  input wire logic        upper_byte_select,
  input wire logic        busy_n,
  input wire logic [11:0] data_output_pins_o,
  input wire logic [11:0] data_output_pins_oe,
  input wire logic        sample_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic strt;
  int   cnt_q;
  int   cnt_d;
  // Start request and busy length
  assign strt = !chip_select_n && !read_n && !upper_byte_select;
  always_comb cnt_d = busy_n ? 0 : cnt_q + 1;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cnt_q <= 0;
    else cnt_q <= cnt_d;
  end
  property p_off; chip_select_n [*4] |-> data_output_pins_oe == 12'h000; endproperty
  a_off: assert property (p_off) else $error("pins driven");
  property p_on; $fell(busy_n) |-> data_output_pins_oe == 12'hFFF; endproperty
  a_on: assert property (p_on) else $error("pins off");
  property p_hi;
    upper_byte_select [*5] ##0 data_output_pins_oe[0]
      |-> data_output_pins_o[7:0] == {4'h0, data_output_pins_o[11:8]};
  endproperty
  a_hi: assert property (p_hi) else $error("bad byte");
  property p_st; $fell(busy_n) |-> $past(strt, 2); endproperty
  a_st: assert property (p_st) else $error("bad start");
  property p_no; !strt [*4] |-> !$fell(busy_n); endproperty
  a_no: assert property (p_no) else $error("stray start");
  property p_len; $rose(busy_n) |-> cnt_q == CONV_CYCLES + 1; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_rdy; $rose(sample_ready) |-> !$past(busy_n); endproperty
  a_rdy: assert property (p_rdy) else $error("stray pop");
  property p_hold;
    !busy_n && !$past(busy_n) && data_output_pins_oe[11] && $past(data_output_pins_oe[11])
      |-> $stable(data_output_pins_o[11:8]);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
endmodule
`default_nettype wire

// file: verification/adcprp_host.sv
`default_nettype none
module adcprp_host (
  input  wire logic        clk_sys,
  input  wire logic        busy_n,
  input  wire logic [11:0] bus,
  output var  logic        chip_select_n,
  output var  logic        read_n,
  output var  logic        upper_byte_select
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {chip_select_n, read_n, upper_byte_select} = 3'b110;
  // One read access, optional wait on busy, then idle gap
  task automatic rd(input logic u, input bit w, input int g, output logic [11:0] d0,
                    output logic [11:0] d1);
    int n;
    @(negedge clk_sys);
    {chip_select_n, read_n, upper_byte_select} = {2'b00, u};
    repeat (4) @(negedge clk_sys);
    d0 = bus;
    for (n = 0; w && !busy_n && n < 200; n++) @(negedge clk_sys);
    d1 = bus;
    {chip_select_n, read_n} = 2'b11;
    repeat (g) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import adcprp_pkg::*;
  localparam int CC = 4;
  logic clk_sys = 0;
  logic reset_n = 0;
  logic sv = 0;
  logic chip_select_n, read_n, upper_byte_select, busy_n, rdy, u, w;
  logic [11:0] dout, oe, bus, d0, d1;
  adcprp_result_t sd = 12'h000;
  int bad_count = 0, total_checks = 0, lat = 0, cyc = 0;
  int q[$];
  // Clock; released pins read inverted
  always #20 clk_sys = ~clk_sys;
  assign bus = (oe & dout) | (~oe & ~dout);
  adcprp_port #(.CONV_CYCLES(CC)) u_adcprp_port (.clk_sys, .reset_n, .chip_select_n, .read_n,
    .upper_byte_select, .busy_n, .data_output_pins_o(dout), .data_output_pins_oe(oe),
    .sample_data(sd), .sample_valid(sv), .sample_ready(rdy));
  adcprp_host u_adcprp_host (.clk_sys, .busy_n, .bus, .chip_select_n, .read_n,
    .upper_byte_select);
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offer one core result
  task automatic push(input logic e);
    @(negedge clk_sys);
    sv = 1;
    sd = 12'($urandom);
    chk(12'(rdy), 12'(e));
    if (rdy) q.push_back(sd);
    @(negedge clk_sys);
    sv = 0;
  endtask
  function automatic logic [11:0] pin(input int v, input logic h);
    return h ? {v[11:8], 4'h0, v[11:8]} : v[11:0];
  endfunction
  // Read through the host and compare with the model
  task automatic rd(input logic h, input bit wt);
    u_adcprp_host.rd(h, wt, wt ? 4 : 20, d0, d1);
    chk(d0, pin(lat, h));
    if (!h) lat = q.pop_front();
    if (wt) chk(d1, pin(lat, h));
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h4716));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1;
    push(1);
    push(1);
    push(0);
    rd(1, 1);
    rd(0, 1);
    rd(0, 0);
    push(1);
    u_adcprp_host.rd(0, 0, 0, d0, d1);
    lat = q.pop_front();
    u_adcprp_host.rd(0, 1, 4, d0, d1);
    chk(d1, 12'(lat));
    repeat (24) begin
      u = 1'($urandom);
      w = 1'($urandom);
      if (!u) push(1);
      rd(u, w);
    end
    end_sim();
  end
endmodule
bind adcprp_port adcprp_chk #(.CONV_CYCLES(CONV_CYCLES)) u_adcprp_chk (.clk_sys, .reset_n,
  .chip_select_n, .read_n, .upper_byte_select, .busy_n, .data_output_pins_o,
  .data_output_pins_oe, .sample_ready);
`default_nettype wire
